/* File: hw/fault_supervisor.sv */
// top: fault classing, lamp drive, fault log and shutdown control
//
// Overview of operation
// - raise command expects height rise in time
// - plausibility error: steady lamp, log, abort control
// - ignition cycle or a remote button press releases plausibility
// - logged faults stay until explicit delete or ignition cycle
// - category I fault disables every function
// - category II keeps remote emergency raise/lower
// - category II sources: param, calib, valve, sensors
// - severe fault: flash lamp, log, shutdown except category II emergency
// - severe shutdown lifts only on ignition cycle
// - transient faults shown while present, always logged
// - report level warnings and faults as messages
// - remote silence is never a fault
// - warning lamp lit while off normal level
// - minor fault: steady lamp, log, limited function
// - flashing pattern overrides steady pattern
`timescale 1ns/1ps
module fault_supervisor #(
  parameter int unsigned PLAUS_TIMEOUT_CYC = fault_sup_pkg::PLAUS_TIMEOUT_CYC,
  parameter int unsigned FLASH_HALF_CYC = fault_sup_pkg::FLASH_HALF_CYC,
  parameter logic [fault_sup_pkg::HEIGHT_W-1:0] MIN_RISE = fault_sup_pkg::MIN_RISE_DEF[fault_sup_pkg::HEIGHT_W-1:0]
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire fault_sup_pkg::level_cmd_s i_cmd,
  input wire logic [fault_sup_pkg::HEIGHT_W-1:0] i_height,
  input wire logic i_at_normal,
  input wire fault_sup_pkg::remote_s i_remote,
  input wire logic i_air_ok,
  input wire logic [fault_sup_pkg::CAT1_W-1:0] i_cat1,
  input wire logic [fault_sup_pkg::CAT2_W-1:0] i_cat2,
  input wire logic i_minor,
  input wire logic i_log_delete,
  output logic o_fault_lamp,
  output logic o_warn_lamp,
  output logic o_control_en,
  output logic o_limited,
  output logic o_system_on,
  output fault_sup_pkg::level_cmd_s o_emerg_cmd,
  output logic o_axle_sel,
  output logic [fault_sup_pkg::LOG_W-1:0] o_fault_log,
  output fault_sup_pkg::can_msg_s o_can
);

  // all inputs here come from pins, so two flops before use
  localparam int unsigned TAIL_W = $bits(i_cat1) + $bits(i_cat2) + $bits(i_minor) + $bits(i_log_delete);
  localparam int unsigned SYNC_W = $bits(i_cmd) + $bits(i_remote) + $bits(i_at_normal) + $bits(i_air_ok) + TAIL_W;
  // level and air pins idle high; the chain resets to that idle so no
  // false off-level edge and no stray level message follow each ignition
  localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(2'h3) << TAIL_W;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
    logic [fault_sup_pkg::HEIGHT_W-1:0] h_meta;
    logic [fault_sup_pkg::HEIGHT_W-1:0] h_sync;
    logic [fault_sup_pkg::CAT1_W-1:0] cat1_latch;
    logic [fault_sup_pkg::CAT2_W-1:0] cat2_latch;
    logic [fault_sup_pkg::CNT_W-1:0] flash_cnt;
    logic flash;
    logic btn_d;
    logic fault_lamp;
    logic warn_lamp;
    logic control_en;
    logic limited;
    logic system_on;
    fault_sup_pkg::level_cmd_s emerg_cmd;
    logic axle_sel;
    logic [fault_sup_pkg::LOG_W-1:0] log;
    logic [fault_sup_pkg::LOG_W-1:0] live_d;
    logic off_d;
    fault_sup_pkg::can_msg_s can;
  } sup_state_s;

  localparam sup_state_s RST_S = '{meta: SYNC_IDLE, sync: SYNC_IDLE, default: '0};

  sup_state_s s, next_s;

  logic [SYNC_W-1:0] raw;
  fault_sup_pkg::level_cmd_s cmd_s;
  fault_sup_pkg::remote_s rem_s;
  logic at_normal_s, air_ok_s, minor_s, del_s;
  logic [fault_sup_pkg::CAT1_W-1:0] cat1_s;
  logic [fault_sup_pkg::CAT2_W-1:0] cat2_s;
  logic plaus_err, btn_press, cat1_act, cat2_act, severe;
  logic [fault_sup_pkg::LOG_W-1:0] live;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // order here fixes the bit positions that SYNC_IDLE relies on
  assign raw = {i_cmd, i_remote, i_at_normal, i_air_ok, i_cat1, i_cat2, i_minor, i_log_delete};
  assign {cmd_s, rem_s, at_normal_s, air_ok_s, cat1_s, cat2_s, minor_s, del_s} = s.sync;

  // ------------------------------------------------------------
  // plausibility
  // ------------------------------------------------------------
  // button press (rising edge) only, no supervision of the remote otherwise
  // the remote talks only now and then, so its silence proves nothing
  assign btn_press = rem_s.button & ~s.btn_d;

  plaus_check #(
    .TIMEOUT_CYC(PLAUS_TIMEOUT_CYC),
    .MIN_RISE(MIN_RISE)
  ) u_plaus (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_cmd(cmd_s),
    .i_height(s.h_sync),
    .i_release(btn_press),
    .o_error(plaus_err)
  );

  // ------------------------------------------------------------
  // fault classing
  // ------------------------------------------------------------
  // severe faults latch until ignition cycle (reset) even once gone
  // so a fault that clears itself still blocks restart until then
  assign cat1_act = |(cat1_s | s.cat1_latch);
  assign cat2_act = |(cat2_s | s.cat2_latch);
  assign severe = cat1_act | cat2_act;
  // log order: plausibility, minor, category I, category II
  assign live = {cat2_s, cat1_s, minor_s, plaus_err};

  // one builder for both message kinds keeps their fields in step
  function automatic fault_sup_pkg::can_msg_s make_msg(input logic [1:0] kind,
      input logic [fault_sup_pkg::LOG_W-1:0] faults, input logic off_level);
    return '{valid: 1'h1, kind: kind, faults: faults, off_level: off_level};
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------

  always_comb begin
    next_s = s;
    next_s.meta = raw;
    next_s.sync = s.meta;
    next_s.h_meta = i_height;
    next_s.h_sync = s.h_meta;
    next_s.btn_d = rem_s.button;
    next_s.cat1_latch = s.cat1_latch | cat1_s;
    next_s.cat2_latch = s.cat2_latch | cat2_s;

    // flash runs free, so a new severe fault may start the lamp dark
    if (s.flash_cnt == fault_sup_pkg::CNT_W'(FLASH_HALF_CYC - 1)) begin
      next_s.flash_cnt = '0;
      next_s.flash = ~s.flash;
    end else begin
      next_s.flash_cnt = s.flash_cnt + 1'b1;
    end

    // lamp: flashing wins over steady
    if (severe) begin
      next_s.fault_lamp = s.flash;
    end else begin
      next_s.fault_lamp = plaus_err | minor_s;
    end
    next_s.warn_lamp = ~at_normal_s;

    // set wins over delete so a new fault is never lost
    if (del_s) begin
      next_s.log = live;
    end else begin
      next_s.log = s.log | live;
    end

    // no way back short of reset: ignition off/on is the only restart
    next_s.system_on = ~severe;
    // plausibility stops control only; lamps, log and messages keep going
    next_s.control_en = ~severe & ~plaus_err;
    next_s.limited = minor_s & ~severe;

    // emergency mode only under category II without category I
    // relay-class faults must keep every valve shut even with air up
    if (cat2_act && !cat1_act && air_ok_s) begin
      next_s.emerg_cmd.raise = rem_s.raise;
      next_s.emerg_cmd.lower = rem_s.lower & ~rem_s.raise;
      next_s.axle_sel = rem_s.axle_sel;
    end else begin
      next_s.emerg_cmd = '0;
      next_s.axle_sel = 1'b0;
    end

    // message on change of fault set or level state
    next_s.live_d = live;
    next_s.off_d = ~at_normal_s;
    next_s.can.valid = 1'b0;
    // a fault change wins the slot; the level state rides in off_level
    if (live != s.live_d) begin
      next_s.can = make_msg(fault_sup_pkg::MSG_FAULT, live, ~at_normal_s);
    end else if (~at_normal_s != s.off_d) begin
      next_s.can = make_msg(fault_sup_pkg::MSG_LEVEL, live, ~at_normal_s);
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_fault_lamp = s.fault_lamp;
  assign o_warn_lamp = s.warn_lamp;
  assign o_control_en = s.control_en;
  assign o_limited = s.limited;
  assign o_system_on = s.system_on;
  assign o_emerg_cmd = s.emerg_cmd;
  assign o_axle_sel = s.axle_sel;
  assign o_fault_log = s.log;
  assign o_can = s.can;

endmodule // fault_supervisor

/* File: hw/fault_sup_pkg.sv */
// package: constants and carrier types for the suspension fault supervisor
package fault_sup_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned PLAUS_TIMEOUT_MS = 2000;
  localparam int unsigned PLAUS_TIMEOUT_CYC = PLAUS_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 32;
  localparam int unsigned HEIGHT_W = 12;
  localparam int unsigned MIN_RISE_DEF = 4;

  // ------------------------------------------------------------
  // fault source bit positions
  // ------------------------------------------------------------
  localparam int unsigned CAT1_W = 3;
  localparam int unsigned CAT1_ROM = 0;
  localparam int unsigned CAT1_RAM = 1;
  localparam int unsigned CAT1_RELAY = 2;
  localparam int unsigned CAT2_W = 5;
  localparam int unsigned CAT2_PARAM = 0;
  localparam int unsigned CAT2_CALIB = 1;
  localparam int unsigned CAT2_VALVE = 2;
  localparam int unsigned CAT2_AXLE_SENS = 3;
  localparam int unsigned CAT2_SENS_REF = 4;
  localparam int unsigned LOG_W = 10;
  localparam int unsigned LOG_PLAUS = 0;
  localparam int unsigned LOG_MINOR = 1;
  localparam int unsigned LOG_CAT1 = 2;
  localparam int unsigned LOG_CAT2 = 2 + CAT1_W;

  // CAN message kinds
  localparam logic [1:0] MSG_LEVEL = 2'h1;
  localparam logic [1:0] MSG_FAULT = 2'h2;

  typedef enum logic [2:0] {
    PL_IDLE = 3'h1,
    PL_WATCH = 3'h2,
    PL_ERROR = 3'h4
  } plaus_e;

  typedef struct packed {
    logic raise;
    logic lower;
  } level_cmd_s;

  typedef struct packed {
    logic button;
    logic raise;
    logic lower;
    logic axle_sel;
  } remote_s;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [LOG_W-1:0] faults;
    logic off_level;
  } can_msg_s;

endpackage

/* File: hw/plaus_check.sv */
// plausibility checker: height response to one raise or lower command
`timescale 1ns/1ps
module plaus_check #(
  parameter int unsigned TIMEOUT_CYC = fault_sup_pkg::PLAUS_TIMEOUT_CYC,
  parameter logic [fault_sup_pkg::HEIGHT_W-1:0] MIN_RISE = fault_sup_pkg::MIN_RISE_DEF[fault_sup_pkg::HEIGHT_W-1:0]
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire fault_sup_pkg::level_cmd_s i_cmd,
  input wire logic [fault_sup_pkg::HEIGHT_W-1:0] i_height,
  input wire logic i_release,
  output logic o_error
);

  typedef struct packed {
    fault_sup_pkg::plaus_e st;
    logic up;
    logic [fault_sup_pkg::HEIGHT_W-1:0] start;
    logic [fault_sup_pkg::CNT_W-1:0] cnt;
  } pc_state_s;

  pc_state_s s, next_s;
  logic moved;

  // direction chosen per command: rise for raise, fall for lower
  always_comb begin
    if (s.up) begin
      moved = (i_height >= s.start) && ((i_height - s.start) >= MIN_RISE);
    end else begin
      moved = (s.start >= i_height) && ((s.start - i_height) >= MIN_RISE);
    end
  end

  always_comb begin
    next_s = s;
    unique case (s.st)
      fault_sup_pkg::PL_IDLE: begin
        if (i_cmd.raise || i_cmd.lower) begin
          next_s.st = fault_sup_pkg::PL_WATCH;
          next_s.up = i_cmd.raise;
          next_s.start = i_height;
          next_s.cnt = '0;
        end
      end
      fault_sup_pkg::PL_WATCH: begin
        if (moved || !(i_cmd.raise || i_cmd.lower)) begin
          next_s.st = fault_sup_pkg::PL_IDLE;
        end else if (s.cnt == fault_sup_pkg::CNT_W'(TIMEOUT_CYC - 1)) begin
          next_s.st = fault_sup_pkg::PL_ERROR;
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      fault_sup_pkg::PL_ERROR: begin
        if (i_release) begin
          next_s.st = fault_sup_pkg::PL_IDLE;
        end
      end
      default: begin
        next_s.st = fault_sup_pkg::PL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s <= '{st: fault_sup_pkg::PL_IDLE, up: 1'b0, start: '0, cnt: '0};
    end else begin
      s <= next_s;
    end
  end

  assign o_error = (s.st == fault_sup_pkg::PL_ERROR);

endmodule // plaus_check

/* File: dv/body_model.sv */
// partner model: body height that follows the raise and lower valve commands
`timescale 1ns/1ps
module body_model (
  input wire logic i_mclk,
  input wire fault_sup_pkg::level_cmd_s i_cmd,
  input wire logic i_stuck,
  output logic [fault_sup_pkg::HEIGHT_W-1:0] o_height
);
  initial o_height = 12'h200;
  // stuck stands for a valve that never fills or vents the bellows
  always @(posedge i_mclk) begin
    if (!i_stuck && i_cmd.raise) o_height <= o_height + 12'h1;
    else if (!i_stuck && i_cmd.lower) o_height <= o_height - 12'h1;
  end
endmodule // body_model

/* File: dv/fault_sup_chk.sv */
// checker: port assertions for the fault supervisor
`timescale 1ns/1ps
module fault_sup_chk #(
  parameter int unsigned PLAUS_TIMEOUT_CYC = 20
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire fault_sup_pkg::level_cmd_s i_cmd,
  input wire logic [fault_sup_pkg::HEIGHT_W-1:0] i_height,
  input wire logic i_at_normal,
  input wire fault_sup_pkg::remote_s i_remote,
  input wire logic [fault_sup_pkg::CAT1_W-1:0] i_cat1,
  input wire logic [fault_sup_pkg::CAT2_W-1:0] i_cat2,
  input wire logic i_minor,
  input wire logic i_log_delete,
  input wire logic o_fault_lamp,
  input wire logic o_warn_lamp,
  input wire logic o_control_en,
  input wire logic o_limited,
  input wire logic o_system_on,
  input wire fault_sup_pkg::level_cmd_s o_emerg_cmd,
  input wire logic [fault_sup_pkg::LOG_W-1:0] o_fault_log,
  input wire fault_sup_pkg::can_msg_s o_can
);
  logic [31:0] stall;
  logic sev_seen;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // flash bounds assume a half period of 4 cycles
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      stall <= 32'h0;
      sev_seen <= 1'b0;
    end else begin
      stall <= (i_cmd.raise && $stable(i_height) && !i_remote.button) ? stall + 32'h1 : 32'h0;
      sev_seen <= sev_seen | (|i_cat1) | (|i_cat2);
    end
  end
  property p_plaus; (stall > PLAUS_TIMEOUT_CYC + 6) |-> !o_control_en; endproperty
  a_plaus: assert property (p_plaus) else $error("stalled raise left control on");
  property p_sev; (|i_cat1 || |i_cat2) |-> ##[2:4] !o_system_on; endproperty
  a_sev: assert property (p_sev) else $error("severe fault left system on");
  property p_cat1; (|i_cat1) |-> ##[2:4] (o_emerg_cmd == '0 && !o_control_en); endproperty
  a_cat1: assert property (p_cat1) else $error("function alive under category one");
  property p_keep; (!i_log_delete)[*5] |-> ((o_fault_log & $past(o_fault_log)) == $past(o_fault_log)); endproperty
  a_keep: assert property (p_keep) else $error("log entry lost without delete");
  property p_warn; (!i_at_normal)[*5] |-> o_warn_lamp; endproperty
  a_warn: assert property (p_warn) else $error("warning lamp dark off level");
  property p_minor; (i_minor && !sev_seen)[*5] |-> (o_fault_lamp && o_limited); endproperty
  a_minor: assert property (p_minor) else $error("minor fault not shown");
  property p_flash; (i_minor && sev_seen && !o_system_on) |-> ##[1:8] $changed(o_fault_lamp); endproperty
  a_flash: assert property (p_flash) else $error("lamp not flashing");
  property p_can; (|(o_fault_log & ~$past(o_fault_log))) |-> (o_can.valid && o_can.kind == fault_sup_pkg::MSG_FAULT); endproperty
  a_can: assert property (p_can) else $error("new fault not messaged");
endmodule // fault_sup_chk
bind fault_supervisor fault_sup_chk #(.PLAUS_TIMEOUT_CYC(PLAUS_TIMEOUT_CYC)) chk_i (.i_mclk, .i_rst, .i_cmd,
  .i_height, .i_at_normal, .i_remote, .i_cat1, .i_cat2, .i_minor, .i_log_delete, .o_fault_lamp, .o_warn_lamp,
  .o_control_en, .o_limited, .o_system_on, .o_emerg_cmd, .o_fault_log, .o_can);

/* File: dv/fault_supervisor_tb_top.sv */
// testbench: directed scenarios for the fault supervisor
`timescale 1ns/1ps
module fault_supervisor_tb_top;
  logic i_mclk = 0, i_rst = 1, i_at_normal = 1, i_air_ok = 1, i_minor = 0, i_log_delete = 0, stuck = 0;
  fault_sup_pkg::level_cmd_s i_cmd = '0;
  fault_sup_pkg::remote_s i_remote = '0;
  logic [2:0] i_cat1 = '0;
  logic [4:0] i_cat2 = '0;
  logic [11:0] i_height;
  logic o_fault_lamp, o_warn_lamp, o_control_en, o_limited, o_system_on, o_axle_sel;
  fault_sup_pkg::level_cmd_s o_emerg_cmd;
  logic [9:0] o_fault_log;
  fault_sup_pkg::can_msg_s o_can;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  fault_sup_pkg::can_msg_s can_last = '0;
  always #2.5 i_mclk = ~i_mclk;
  // valid stands one cycle: keep the last message for the scenarios
  always @(posedge i_mclk) begin
    if (o_can.valid) can_last <= o_can;
  end
  body_model bm (.i_mclk, .i_cmd, .i_stuck(stuck), .o_height(i_height));
  fault_supervisor #(.PLAUS_TIMEOUT_CYC(20), .FLASH_HALF_CYC(4)) dut (.i_mclk, .i_rst, .i_cmd, .i_height,
    .i_at_normal, .i_remote, .i_air_ok, .i_cat1, .i_cat2, .i_minor, .i_log_delete, .o_fault_lamp, .o_warn_lamp,
    .o_control_en, .o_limited, .o_system_on, .o_emerg_cmd, .o_axle_sel, .o_fault_log, .o_can);
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ignition off then on
  task automatic do_reset;
    @(posedge i_mclk);
    i_rst <= 1'b1;
    {i_cat1, i_cat2, i_minor, i_cmd, i_remote, stuck} <= '0;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    tick(6);
  endtask
  task automatic t_raise_ok;
    @(posedge i_mclk);
    {i_cmd.raise, i_at_normal} <= 2'h2;
    tick(40);
    chk("control_en", 10'h1, o_control_en);
    chk("warn_lamp", 10'h1, o_warn_lamp);
    chk("fault_log", 10'h0, o_fault_log);
    chk("can_kind", fault_sup_pkg::MSG_LEVEL, can_last.kind);
    chk("can_off_level", 10'h1, can_last.off_level);
  endtask
  task automatic t_plaus;
    @(posedge i_mclk);
    {i_cmd.raise, stuck, i_at_normal} <= 3'h7;
    tick(32);
    chk("control_en", 10'h0, o_control_en);
    chk("fault_lamp", 10'h1, o_fault_lamp);
    chk("fault_log", 10'h1, o_fault_log);
    chk("can_kind", fault_sup_pkg::MSG_FAULT, can_last.kind);
    chk("can_faults", 10'h1, can_last.faults);
    @(posedge i_mclk);
    {i_cmd.raise, stuck, i_remote.button} <= 3'h1;
    repeat (2) @(posedge i_mclk);
    i_remote.button <= 1'b0;
    tick(6);
    chk("control_en", 10'h1, o_control_en);
    chk("fault_lamp", 10'h0, o_fault_lamp);
    chk("fault_log", 10'h1, o_fault_log);
    @(posedge i_mclk);
    i_log_delete <= 1'b1;
    @(posedge i_mclk);
    i_log_delete <= 1'b0;
    tick(6);
    chk("fault_log", 10'h0, o_fault_log);
  endtask
  // stuck lower command, released by an ignition cycle
  task automatic t_lower;
    @(posedge i_mclk);
    {i_cmd.lower, stuck} <= 2'h3;
    tick(32);
    chk("control_en", 10'h0, o_control_en);
    chk("fault_log", 10'h1, o_fault_log);
    do_reset;
    chk("control_en", 10'h1, o_control_en);
  endtask
  task automatic t_severe;
    for (int i = 0; i < 8; i++) begin
      do_reset;
      @(posedge i_mclk);
      {i_cat2, i_cat1} <= (i < 5) ? 8'h8 << i : 8'h1 << (i - 5);
      i_remote <= 4'h5;
      tick(6);
      chk("system_on", 10'h0, o_system_on);
      chk("emerg_cmd", (i < 5) ? 10'h2 : 10'h0, o_emerg_cmd);
      chk("axle_sel", (i < 5) ? 10'h1 : 10'h0, o_axle_sel);
      chk("fault_log", (i < 5) ? 10'h20 << i : 10'h4 << (i - 5), o_fault_log);
      @(posedge i_mclk);
      {i_air_ok, i_cat1, i_cat2} <= '0;
      tick(6);
      chk("emerg_cmd", 10'h0, o_emerg_cmd);
      chk("system_on", 10'h0, o_system_on);
      @(posedge i_mclk);
      i_air_ok <= 1'b1;
    end
    do_reset;
    chk("system_on", 10'h1, o_system_on);
  endtask
  task automatic t_minor;
    int n;
    logic last;
    n = 0;
    @(posedge i_mclk);
    i_minor <= 1'b1;
    tick(6);
    chk("limited", 10'h1, o_limited);
    @(posedge i_mclk);
    i_minor <= 1'b0;
    tick(6);
    chk("fault_lamp", 10'h0, o_fault_lamp);
    chk("fault_log", 10'h2, o_fault_log);
    @(posedge i_mclk);
    {i_minor, i_cat2} <= 6'h21;
    tick(6);
    last = o_fault_lamp;
    repeat (10) begin
      tick(1);
      n += (o_fault_lamp !== last);
      last = o_fault_lamp;
    end
    chk("flash", 10'h1, n >= 2);
    chk("limited", 10'h0, o_limited);
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    do_reset;
    t_raise_ok;
    t_plaus;
    t_lower;
    t_severe;
    t_minor;
    final_report;
  end
endmodule // fault_supervisor_tb_top
